//--- rtl/split_timer_and_timer_two.sv
// timer 0 split mode and 16-bit timer two with capture, reload and baud modes
`timescale 1ns/1ps
`default_nettype none
module split_timer_and_timer_two (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // timer 0 and timer 1 controls held elsewhere
   input wire logic first_timer_mode3,
   input wire logic second_timer_mode3,
   input wire logic first_timer_counter_select,
   input wire logic first_timer_gate,
   input wire logic first_timer_run,
   input wire logic second_timer_run,
   input wire logic first_timer_flag_clear,
   input wire logic second_timer_flag_clear,
   input wire logic second_timer_overflow_pulse,
   // external pins
   input wire logic external_interrupt_zero_in,
   input wire logic first_timer_count_in,
   input wire logic t_two_count_in,
   input wire logic t_two_trigger_input,
   // outputs
   output logic first_timer_overflow_flag,
   output logic second_timer_overflow_flag,
   output logic second_timer_halt,
   output logic t_two_irq,
   output logic serial_rx_clock,
   output logic serial_tx_clock,
   output logic t_two_clock_out
);

   typedef struct packed {
      logic [3:0] mc_cnt;
      logic ovf_flag;
      logic ext_flag;
      logic rx_src;
      logic tx_src;
      logic trig_en;
      logic run;
      logic cnt_sel;
      logic cap_sel;
      logic clkout_en;
      logic down_en;
      logic [15:0] count;
      logic [15:0] reload;
      logic [7:0] low0;
      logic [7:0] high0;
      logic flag0;
      logic flag1;
      logic trig_q;
      logic pin2_q;
      logic pin0_q;
      logic irq;
      logic rxclk;
      logic txclk;
      logic clkout;
      logic halt1;
      logic [7:0] rdata;
   } state_t;

   state_t st_ff;
   state_t nxt_st;
   logic mc_en;
   logic baud;
   logic tick;
   logic ovf;
   logic trig;
   logic reload_mode;
   logic tick0;
   logic tick0h;

   always_comb begin
      nxt_st = st_ff;
      mc_en = (st_ff.mc_cnt == split_timer_pkg::MC_LAST);
      baud = st_ff.rx_src | st_ff.tx_src;
      reload_mode = baud | ~st_ff.cap_sel;
      // machine cycle divider
      nxt_st.mc_cnt = mc_en ? split_timer_pkg::MC_RESET : st_ff.mc_cnt + 4'h1;
      // pins sampled once per machine cycle
      if (mc_en) begin
         nxt_st.trig_q = t_two_trigger_input;
         nxt_st.pin2_q = t_two_count_in;
         nxt_st.pin0_q = first_timer_count_in;
      end
      trig = mc_en & st_ff.trig_q & ~t_two_trigger_input
         & st_ff.trig_en & ~baud;
      // timer two count event
      tick = st_ff.run & mc_en
         & (st_ff.cnt_sel ? (st_ff.pin2_q & ~t_two_count_in) : 1'b1);
      ovf = 1'b0;
      if (tick) begin
         if (st_ff.down_en) begin
            if ((reload_mode && st_ff.count == st_ff.reload) ||
                st_ff.count == split_timer_pkg::RESET_WORD) begin
               ovf = 1'b1;
               nxt_st.count = split_timer_pkg::WORD_MAX;
            end else begin
               nxt_st.count = st_ff.count - 16'h0001;
            end
         end else if (st_ff.count == split_timer_pkg::WORD_MAX) begin
            ovf = 1'b1;
            nxt_st.count = reload_mode ? st_ff.reload
               : split_timer_pkg::RESET_WORD;
         end else begin
            nxt_st.count = st_ff.count + 16'h0001;
         end
      end
      // trigger edge: capture or early reload
      if (trig && st_ff.cap_sel) begin
         nxt_st.reload = st_ff.count;
      end
      if (trig && !st_ff.cap_sel) begin
         nxt_st.count = st_ff.reload;
      end
      // timer 0 split mode
      tick0 = first_timer_mode3 & first_timer_run & mc_en
         & (~first_timer_gate | external_interrupt_zero_in)
         & (first_timer_counter_select ? (st_ff.pin0_q & ~first_timer_count_in)
         : 1'b1);
      tick0h = first_timer_mode3 & second_timer_run & mc_en;
      if (tick0) begin
         nxt_st.low0 = st_ff.low0 + 8'h01;
      end
      if (tick0h) begin
         nxt_st.high0 = st_ff.high0 + 8'h01;
      end
      nxt_st.flag0 = (st_ff.flag0 & ~first_timer_flag_clear)
         | (tick0 & st_ff.low0 == split_timer_pkg::BYTE_MAX);
      nxt_st.flag1 = (st_ff.flag1 & ~second_timer_flag_clear)
         | (tick0h & st_ff.high0 == split_timer_pkg::BYTE_MAX);
      nxt_st.halt1 = second_timer_mode3;
      // software writes; hardware sets win over a clear in the same cycle
      if (sfr_wr) begin
         case (sfr_addr)
            split_timer_pkg::ADDR_T2_CONTROL: begin
               nxt_st.ovf_flag = sfr_wdata[split_timer_pkg::BIT_OVF];
               nxt_st.ext_flag = sfr_wdata[split_timer_pkg::BIT_EXT];
               nxt_st.rx_src = sfr_wdata[split_timer_pkg::BIT_RCLK];
               nxt_st.tx_src = sfr_wdata[split_timer_pkg::BIT_SERIAL_TX_CLOCK_SOURCE];
               nxt_st.trig_en = sfr_wdata[split_timer_pkg::BIT_EXEN];
               nxt_st.run = sfr_wdata[split_timer_pkg::BIT_RUN];
               nxt_st.cnt_sel = sfr_wdata[split_timer_pkg::BIT_CNT];
               nxt_st.cap_sel = sfr_wdata[split_timer_pkg::BIT_CPRL];
            end
            split_timer_pkg::ADDR_T2_MODE: begin
               nxt_st.clkout_en = sfr_wdata[split_timer_pkg::BIT_CLKOUT];
               nxt_st.down_en = sfr_wdata[split_timer_pkg::BIT_DOWN];
            end
            split_timer_pkg::ADDR_RELOAD_LOW: nxt_st.reload[7:0] = sfr_wdata;
            split_timer_pkg::ADDR_RELOAD_HIGH: nxt_st.reload[15:8] = sfr_wdata;
            split_timer_pkg::ADDR_COUNT_LOW: nxt_st.count[7:0] = sfr_wdata;
            split_timer_pkg::ADDR_COUNT_HIGH: nxt_st.count[15:8] = sfr_wdata;
            split_timer_pkg::ADDR_FIRST_LOW: nxt_st.low0 = sfr_wdata;
            split_timer_pkg::ADDR_FIRST_HIGH: nxt_st.high0 = sfr_wdata;
            default: begin
            end
         endcase
      end
      if (ovf && !baud) begin
         nxt_st.ovf_flag = 1'b1;
      end
      if (trig) begin
         nxt_st.ext_flag = 1'b1;
      end
      nxt_st.irq = st_ff.ovf_flag | st_ff.ext_flag;
      // serial clock selection
      nxt_st.rxclk = st_ff.rx_src ? ovf : second_timer_overflow_pulse;
      nxt_st.txclk = st_ff.tx_src ? ovf : second_timer_overflow_pulse;
      if (ovf && st_ff.clkout_en) begin
         nxt_st.clkout = ~st_ff.clkout;
      end
      // read data
      if (sfr_rd) begin
         case (sfr_addr)
            split_timer_pkg::ADDR_T2_CONTROL: nxt_st.rdata = {st_ff.ovf_flag,
               st_ff.ext_flag, st_ff.rx_src, st_ff.tx_src, st_ff.trig_en,
               st_ff.run, st_ff.cnt_sel, st_ff.cap_sel};
            split_timer_pkg::ADDR_T2_MODE: nxt_st.rdata = {6'h00, st_ff.clkout_en,
               st_ff.down_en};
            split_timer_pkg::ADDR_RELOAD_LOW: nxt_st.rdata = st_ff.reload[7:0];
            split_timer_pkg::ADDR_RELOAD_HIGH: nxt_st.rdata = st_ff.reload[15:8];
            split_timer_pkg::ADDR_COUNT_LOW: nxt_st.rdata = st_ff.count[7:0];
            split_timer_pkg::ADDR_COUNT_HIGH: nxt_st.rdata = st_ff.count[15:8];
            split_timer_pkg::ADDR_FIRST_LOW: nxt_st.rdata = st_ff.low0;
            split_timer_pkg::ADDR_FIRST_HIGH: nxt_st.rdata = st_ff.high0;
            default: nxt_st.rdata = split_timer_pkg::RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sfr_rdata = st_ff.rdata;
   assign first_timer_overflow_flag = st_ff.flag0;
   assign second_timer_overflow_flag = st_ff.flag1;
   assign second_timer_halt = st_ff.halt1;
   assign t_two_irq = st_ff.irq;
   assign serial_rx_clock = st_ff.rxclk;
   assign serial_tx_clock = st_ff.txclk;
   assign t_two_clock_out = st_ff.clkout;

   // checks
   logic ctl_wr;
   logic cnt_wr;
   logic rel_wr;
   assign ctl_wr = sfr_wr && sfr_addr == split_timer_pkg::ADDR_T2_CONTROL;
   assign cnt_wr = sfr_wr && (sfr_addr == split_timer_pkg::ADDR_COUNT_LOW
      || sfr_addr == split_timer_pkg::ADDR_COUNT_HIGH);
   assign rel_wr = sfr_wr && (sfr_addr == split_timer_pkg::ADDR_RELOAD_LOW
      || sfr_addr == split_timer_pkg::ADDR_RELOAD_HIGH);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   mc_period_a: assert property (mc_en |=> !mc_en [*8] ##1 !mc_en [*3] ##1 mc_en)
      else $error("machine cycle enable period is not twelve clocks");
   halt_follow_a: assert property (second_timer_halt == $past(second_timer_mode3, 1))
      else $error("timer 1 halt does not follow its mode 3 select");
   ovf_flag_set_a: assert property (ovf && !baud |=> st_ff.ovf_flag)
      else $error("overflow flag not set on overflow");
   baud_no_flag_a: assert property (baud && !ctl_wr && !st_ff.ovf_flag
      |=> !st_ff.ovf_flag)
      else $error("overflow flag set in baud mode");
   capture_copy_a: assert property (trig && st_ff.cap_sel && !rel_wr
      |=> st_ff.reload == $past(st_ff.count))
      else $error("capture pair does not hold the count at the edge");
   reload_roll_a: assert property (ovf && reload_mode && !st_ff.down_en && !cnt_wr
      |=> st_ff.count == $past(st_ff.reload))
      else $error("count not reloaded on rollover");
   trig_ignored_a: assert property ((!st_ff.trig_en || baud) && !ctl_wr
      && !st_ff.ext_flag |=> !st_ff.ext_flag)
      else $error("external flag set while trigger is ignored");
   irq_shared_a: assert property ((st_ff.ovf_flag || st_ff.ext_flag) |=> t_two_irq)
      else $error("interrupt request missing while a flag is set");
   high_byte_a: assert property (tick0h && !sfr_wr
      |=> st_ff.high0 == $past(st_ff.high0) + 8'h01)
      else $error("split high byte did not count");
   rx_select_a: assert property (st_ff.rx_src && !ctl_wr ##1 st_ff.rx_src
      |-> serial_rx_clock == $past(ovf))
      else $error("receive clock not taken from timer two overflow");

   capture_seen_c: cover property (trig && st_ff.cap_sel);
   baud_ovf_c: cover property (ovf && baud);
   split_high_ovf_c: cover property (tick0h && st_ff.high0 == split_timer_pkg::BYTE_MAX);

endmodule // split_timer_and_timer_two
`default_nettype wire

//--- pkg/split_timer_pkg.sv
// constants shared by the split timer and timer two block
package split_timer_pkg;
   // special function register addresses
   localparam logic [7:0] ADDR_T2_CONTROL = 8'hc8;
   localparam logic [7:0] ADDR_T2_MODE = 8'hc9;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
   localparam logic [7:0] ADDR_FIRST_LOW = 8'h8a;
   localparam logic [7:0] ADDR_FIRST_HIGH = 8'h8c;
   // control register bit positions
   localparam int BIT_OVF = 7;
   localparam int BIT_EXT = 6;
   localparam int BIT_RCLK = 5;
   localparam int BIT_SERIAL_TX_CLOCK_SOURCE = 4;
   localparam int BIT_EXEN = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_CNT = 1;
   localparam int BIT_CPRL = 0;
   // mode register bit positions
   localparam int BIT_CLKOUT = 1;
   localparam int BIT_DOWN = 0;
   // values after reset and count limits
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [15:0] WORD_MAX = 16'hffff;
   localparam logic [7:0] BYTE_MAX = 8'hff;
   // machine cycle: twelve oscillator phases of sys_clk
   localparam int OSC_PHASES_PER_MC = 12;
   localparam logic [3:0] MC_LAST = 4'(OSC_PHASES_PER_MC - 1);
   localparam logic [3:0] MC_RESET = 4'h0;
endpackage

//--- verif/pin_driver.sv
// far-side model of the timer two trigger and count pins
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // request for one falling edge on the trigger pin
   input wire logic fire,
   // pins toward the block
   output logic trig_pin,
   output logic count_pin
);
   logic [5:0] hold_ff;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hold_ff <= 6'h00;
      end else if (fire) begin
         hold_ff <= 6'h24;
      end else if (hold_ff != 6'h00) begin
         hold_ff <= hold_ff - 6'h01;
      end
   end
   // low level held three machine cycles so the sampled edge is never missed
   assign trig_pin = (hold_ff == 6'h00);
   // count pin copies the trigger pin so one request gives one counted edge
   assign count_pin = trig_pin;
endmodule // pin_driver
`default_nettype wire

//--- verif/tb.sv
// self-checking testbench of the split timer and timer two block
`timescale 1ns/1ps
`default_nettype none
`define check(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   logic sys_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, trig_fire = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, exp_v;
   logic t3 = 1'b0, t1m3 = 1'b0, irq, tx_clk, halt, trig, cnt, rd_seen = 1'b0;
   logic f0, f1, rx_clk, clk_out;
   logic [15:0] v, c;
   logic [7:0] exp_q[$];
   int errors = 0, comparisons = 0;
   always #5 sys_clk = ~sys_clk;
   pin_driver i_pin_driver (.sys_clk(sys_clk), .rst(rst), .fire(trig_fire), .trig_pin(trig),
      .count_pin(cnt));
   split_timer_and_timer_two i_split_timer_and_timer_two (.sys_clk(sys_clk), .rst(rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .first_timer_mode3(t3), .second_timer_mode3(t1m3),
      .first_timer_counter_select(1'b0), .first_timer_gate(1'b0), .first_timer_run(t3),
      .second_timer_run(t3), .first_timer_flag_clear(1'b0), .second_timer_flag_clear(t1m3),
      .second_timer_overflow_pulse(t1m3), .external_interrupt_zero_in(t3),
      .first_timer_count_in(cnt), .t_two_count_in(cnt), .t_two_trigger_input(trig),
      .first_timer_overflow_flag(f0), .second_timer_overflow_flag(f1),
      .second_timer_halt(halt), .t_two_irq(irq), .serial_rx_clock(rx_clk),
      .serial_tx_clock(tx_clk), .t_two_clock_out(clk_out));
   // read data is valid in the cycle after the read strobe is taken
   always @(posedge sys_clk) rd_seen <= sfr_rd;
   always @(negedge sys_clk) begin
      if (rd_seen) begin
         exp_v = exp_q.pop_front();
         `check(sfr_rdata, exp_v)
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic wr_count(input logic [15:0] d);
      wr(split_timer_pkg::ADDR_COUNT_LOW, d[7:0]);
      wr(split_timer_pkg::ADDR_COUNT_HIGH, d[15:8]);
   endtask
   task automatic rd_pair(input logic [7:0] a, input logic [15:0] e);
      rd(a, e[7:0]);
      rd(a + 8'h01, e[15:8]);
   endtask
   task automatic pulse_trigger();
      @(posedge sys_clk);
      trig_fire <= 1'b1;
      @(posedge sys_clk);
      trig_fire <= 1'b0;
      repeat (60) @(posedge sys_clk);
   endtask
   task automatic wait_high(ref logic s);
      @(negedge sys_clk);
      for (int i = 0; i < 200 && s !== 1'b1; i++) @(negedge sys_clk);
      `check(s, 1'b1)
   endtask
   task automatic give_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #200us;
      errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(96));
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      wr(split_timer_pkg::ADDR_T2_MODE, 8'hff);
      rd(split_timer_pkg::ADDR_T2_MODE, 8'h03);
      wr(split_timer_pkg::ADDR_T2_MODE, 8'h00);
      rd(8'h00, 8'h00);
      v = 16'($urandom);
      wr(split_timer_pkg::ADDR_RELOAD_LOW, v[7:0]);
      wr(split_timer_pkg::ADDR_RELOAD_HIGH, v[15:8]);
      rd_pair(split_timer_pkg::ADDR_RELOAD_LOW, v);
      $display("test registers done");
      wr_count(16'hffff);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h04);
      wait_high(irq);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h80);
      rd(split_timer_pkg::ADDR_T2_CONTROL, 8'h80);
      rd_pair(split_timer_pkg::ADDR_COUNT_LOW, v);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h00);
      repeat (3) @(posedge sys_clk);
      `check(irq, 1'b0)
      $display("test auto reload done");
      c = 16'($urandom);
      wr_count(c);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h09);
      pulse_trigger();
      rd_pair(split_timer_pkg::ADDR_RELOAD_LOW, c);
      rd(split_timer_pkg::ADDR_T2_CONTROL, 8'h49);
      `check(irq, 1'b1)
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h08);
      wr_count(16'($urandom));
      pulse_trigger();
      rd_pair(split_timer_pkg::ADDR_COUNT_LOW, c);
      rd(split_timer_pkg::ADDR_T2_CONTROL, 8'h48);
      $display("test trigger done");
      v = 16'($urandom);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h18);
      wr_count(v);
      pulse_trigger();
      rd_pair(split_timer_pkg::ADDR_COUNT_LOW, v);
      rd(split_timer_pkg::ADDR_T2_CONTROL, 8'h18);
      wr_count(16'hffff);
      wr(split_timer_pkg::ADDR_T2_MODE, 8'h02);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h34);
      wait_high(tx_clk);
      `check(rx_clk, 1'b1)
      `check(clk_out, 1'b1)
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h30);
      rd(split_timer_pkg::ADDR_T2_CONTROL, 8'h30);
      rd_pair(split_timer_pkg::ADDR_COUNT_LOW, c);
      $display("test baud done");
      wr_count(16'h0000);
      wr(split_timer_pkg::ADDR_T2_MODE, 8'h01);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h05);
      wait_high(irq);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h81);
      rd_pair(split_timer_pkg::ADDR_COUNT_LOW, 16'hffff);
      rd(split_timer_pkg::ADDR_T2_CONTROL, 8'h81);
      wr(split_timer_pkg::ADDR_T2_MODE, 8'h00);
      $display("test count down done");
      wr_count(16'h1234);
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h06);
      pulse_trigger();
      wr(split_timer_pkg::ADDR_T2_CONTROL, 8'h00);
      rd_pair(split_timer_pkg::ADDR_COUNT_LOW, 16'h1235);
      rd(split_timer_pkg::ADDR_T2_CONTROL, 8'h00);
      $display("test counter done");
      wr(split_timer_pkg::ADDR_FIRST_LOW, 8'hfe);
      wr(split_timer_pkg::ADDR_FIRST_HIGH, 8'hff);
      @(posedge sys_clk);
      t3 <= 1'b1;
      wait_high(f1);
      wait_high(f0);
      @(posedge sys_clk);
      t3 <= 1'b0;
      rd(split_timer_pkg::ADDR_FIRST_LOW, 8'h00);
      rd(split_timer_pkg::ADDR_FIRST_HIGH, 8'h01);
      $display("test split done");
      @(posedge sys_clk);
      t1m3 <= 1'b1;
      repeat (3) @(posedge sys_clk);
      `check(halt, 1'b1)
      `check(rx_clk, 1'b1)
      $display("test halt done");
      give_verdict();
   end
endmodule // tb
`default_nettype wire
